//--- pkg/rpw_defs.svh
// Constants for reset pin sequencer and software watchdog
`ifndef RPW_DEFS_SVH
`define RPW_DEFS_SVH
// Reset pin drive and settle lengths, bus cycles
`define RPW_DRIVE_LAST 6'h21
`define RPW_SETTLE_LAST 6'h25
// Watchdog terminal counts, 2^18 and 2^13 cycles
`define RPW_WD_LONG_MAX 18'h3FFFF
`define RPW_WD_SHORT_MAX 18'h01FFF
// Debug link bit time, 16 cycles
`define RPW_BIT_LAST 4'hF
// Shared general-purpose pin count
`define RPW_GPIO_N 55
// Register byte offsets
`define RPW_ADDR_CAUSE 12'h000
`define RPW_ADDR_OPTS 12'h004
`define RPW_ADDR_PORTG 12'h008
`define RPW_ADDR_STAT 12'h00C
// Cause flag positions
`define RPW_C_POR 7
`define RPW_C_PIN 6
`define RPW_C_WDOG 5
`define RPW_C_ILOP 4
`define RPW_C_CLK 2
`define RPW_C_LVD 1
// Option field positions and reset values
`define RPW_O_EN 0
`define RPW_O_LONG 1
`define RPW_O_LOCK 2
`define RPW_EN_RST 1'b1
`define RPW_LONG_RST 1'b1
// Cause register value after power-on
`define RPW_CAUSE_POR 8'h80
// Port bit field positions
`define RPW_P_EN 0
`define RPW_P_VAL 1
// AXI responses
`define RPW_RESP_OK 2'h0
`define RPW_RESP_SLVERR 2'h2
`endif

//--- pkg/rpw_pkg.sv
// Types for reset pin sequencer and software watchdog
package rpw_pkg;
  typedef enum logic [1:0] {
    RPW_RUN = 2'b00,
    RPW_DRIVE = 2'b01,
    RPW_SETTLE = 2'b10,
    RPW_HOLD = 2'b11
  } rpw_seq_e;
  typedef logic [7:0] rpw_cause_t;
endpackage

//--- pkg/rpw_wd_if.sv
// Control and status bundle between sequencer and watchdog
`timescale 1ns/1ps
interface rpw_wd_if;
  logic enable;
  logic period_long;
  logic service;
  logic suspend;
  logic clear;
  logic timeout;
  modport ctrl (output enable, output period_long, output service,
    output suspend, output clear, input timeout);
  modport wdog (input enable, input period_long, input service,
    input suspend, input clear, output timeout);
endinterface

//--- hw/rpw_wdog.sv
// Software watchdog counter with two timeout periods
`timescale 1ns/1ps
`include "rpw_defs.svh"
module rpw_wdog
  import rpw_pkg::*;
(
  input wire logic aclk, // Bus clock
  input wire logic aresetn, // Synchronous reset, active low
  rpw_wd_if.wdog wd // Control from sequencer
);
  logic [17:0] cnt_r;
  logic [17:0] limit;
  logic timeout_r;
  logic run;

  // Terminal count from period select
  assign limit = wd.period_long ? `RPW_WD_LONG_MAX : `RPW_WD_SHORT_MAX;
  assign run = wd.enable && !wd.suspend;
  assign wd.timeout = timeout_r;

  // Counter: cleared by reset and service, counts while running
  always_ff @(posedge aclk) begin
    if (!aresetn || wd.clear || wd.service || timeout_r) begin
      cnt_r <= 18'h00000;
    end else if (run && cnt_r != limit) begin
      cnt_r <= cnt_r + 18'h00001;
    end
  end

  // Timeout pulse on reaching terminal count
  always_ff @(posedge aclk) begin
    if (!aresetn || wd.clear || wd.service) begin
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= run && cnt_r == limit && !timeout_r;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_wd_clear_zero: assert property ((wd.clear || wd.service) |=> cnt_r == 18'h00000)
    else $error("watchdog count not cleared");
  a_wd_suspend_hold: assert property ((wd.suspend && !wd.clear && !wd.service && !timeout_r)
    |=> $stable(cnt_r))
    else $error("watchdog counted while suspended");
  a_wd_period_end: assert property ($rose(timeout_r) |-> $past(cnt_r) == $past(limit))
    else $error("watchdog timeout at wrong count");
  a_wd_off_quiet: assert property ((!wd.enable && !timeout_r) |=> !timeout_r)
    else $error("watchdog fired while disabled");
endmodule

//--- hw/rpw_top.sv
// Reset pin sequencer, reset cause, mode select and watchdog control
//
// Behaviour
// - Any reset: pin low 34, sample 38 later
// - Internal reset expects high sample; low means pin
// - Decode cause, set flag in cause register
// - Sources lvd, ilop, pin, clock loss, debug force
// - Self clock mode; counts in bus cycles
// - Released pin pulled high unless held low
// - Debug pin is mode select during reset
// - Low at release gives background mode
// - Debug bit time is 16 clock cycles
// - Pseudo open drain with high speedup pulses
// - As port bit, debug pin outputs only
// - After reset 55 pins inputs, pullups off
// - Watchdog timeout forces system reset
// - Write to cause address restarts watchdog
// - Watchdog enabled after any reset
// - Write-once options; clearing enable disables watchdog
// - Period select picks 2^18 or 2^13
// - Watchdog suspended in background mode
`timescale 1ns/1ps
`include "rpw_defs.svh"
module rpw_top
  import rpw_pkg::*;
(
  input wire logic aclk, // Bus clock
  input wire logic aresetn, // Power-on reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic lvd_det, // Low-voltage detect event
  input wire logic ilop_det, // Illegal opcode event
  input wire logic clk_loss_det, // Clock generator lock or clock loss
  input wire logic dbg_force_rst, // Debug-forced reset request
  input wire logic rst_pin_n_in, // Reset pin level
  output logic rst_pin_n_out, // Reset pin drive value
  output logic rst_pin_n_oe, // Reset pin drive enable
  input wire logic dbg_pin_in, // Debug pin level
  output logic dbg_pin_out, // Debug pin drive value
  output logic dbg_pin_oe, // Debug pin drive enable
  input wire logic bdc_drive_low, // Debug link drives low
  input wire logic bdc_speedup, // Debug link speedup pulse
  output logic dbg_bit_tick, // End of debug bit time
  output logic sys_rst_n, // System reset, active low
  output logic clk_self_mode, // Clock generator in self-clocked mode
  output logic bg_mode, // Active background mode
  output logic gpio_default // Shared pins forced to input, no pullup
);
  rpw_seq_e state_r;
  logic [5:0] cnt_r;
  rpw_cause_t pend_r;
  rpw_cause_t cause_r;
  rpw_cause_t src_now;
  logic rst_s1_r, rst_s2_r;
  logic dbg_s1_r, dbg_s2_r, dbg_s3_r;
  logic trig;
  logic in_run;
  logic opt_en_r, opt_long_r, opt_lock_r;
  logic pg_en_r, pg_val_r;
  logic wd_service_r;
  logic [3:0] bit_ph_r;
  logic aw_hold_r, w_hold_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic [31:0] rd_val;
  logic rd_err;
  rpw_wd_if wd ();

  assign in_run = state_r == RPW_RUN;

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
      dbg_s1_r <= 1'b1;
      dbg_s2_r <= 1'b1;
      dbg_s3_r <= 1'b1;
    end else begin
      rst_s1_r <= rst_pin_n_in;
      rst_s2_r <= rst_s1_r;
      dbg_s1_r <= dbg_pin_in;
      dbg_s2_r <= dbg_s1_r;
      dbg_s3_r <= dbg_s2_r;
    end
  end

  // Internal sources present this cycle
  always_comb begin
    src_now = 8'h00;
    src_now[`RPW_C_LVD] = lvd_det;
    src_now[`RPW_C_ILOP] = ilop_det;
    src_now[`RPW_C_CLK] = clk_loss_det;
    src_now[`RPW_C_WDOG] = wd.timeout;
  end

  // Any source, debug force has no flag, pin low from outside
  assign trig = (|src_now) || dbg_force_rst || !rst_s2_r;

  // Reset pin sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= RPW_DRIVE;
      cnt_r <= 6'h00;
      pend_r <= `RPW_CAUSE_POR;
    end else begin
      case (state_r)
        RPW_RUN: begin
          if (trig) begin
            state_r <= RPW_DRIVE;
            cnt_r <= 6'h00;
            pend_r <= src_now;
          end
        end
        RPW_DRIVE: begin
          pend_r <= pend_r | src_now;
          if (cnt_r == `RPW_DRIVE_LAST) begin
            state_r <= RPW_SETTLE;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        RPW_SETTLE: begin
          pend_r <= pend_r | src_now;
          if (cnt_r == `RPW_SETTLE_LAST) begin
            cnt_r <= 6'h00;
            state_r <= rst_s2_r ? RPW_RUN : RPW_HOLD;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        RPW_HOLD: begin
          if (rst_s2_r) begin
            state_r <= RPW_RUN;
          end
        end
        default: begin
          state_r <= RPW_DRIVE;
          cnt_r <= 6'h00;
        end
      endcase
    end
  end

  // Cause register loaded at the delayed pin sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= `RPW_CAUSE_POR;
    end else if (state_r == RPW_SETTLE && cnt_r == `RPW_SETTLE_LAST) begin
      cause_r <= pend_r;
      cause_r[`RPW_C_PIN] <= !rst_s2_r;
    end
  end

  // Pin drive, system reset and clock mode outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_pin_n_oe <= 1'b1;
      rst_pin_n_out <= 1'b0;
      sys_rst_n <= 1'b0;
      clk_self_mode <= 1'b1;
      gpio_default <= 1'b1;
    end else begin
      rst_pin_n_out <= 1'b0;
      rst_pin_n_oe <= (state_r == RPW_RUN && trig) ||
        (state_r == RPW_DRIVE && cnt_r != `RPW_DRIVE_LAST);
      sys_rst_n <= (in_run && !trig) || (state_r == RPW_HOLD && rst_s2_r) ||
        (state_r == RPW_SETTLE && cnt_r == `RPW_SETTLE_LAST && rst_s2_r);
      clk_self_mode <= !(in_run && !trig);
      gpio_default <= !in_run;
    end
  end

  // Mode select sampled at reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_mode <= 1'b0;
    end else if (!sys_rst_n && state_r != RPW_DRIVE) begin
      bg_mode <= !dbg_s2_r;
    end
  end

  // Debug pin: quiet in reset, port bit output only, else open drain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_pin_oe <= 1'b0;
      dbg_pin_out <= 1'b0;
    end else if (!in_run) begin
      dbg_pin_oe <= 1'b0;
      dbg_pin_out <= 1'b0;
    end else if (pg_en_r) begin
      dbg_pin_oe <= 1'b1;
      dbg_pin_out <= pg_val_r;
    end else begin
      dbg_pin_oe <= bdc_drive_low || bdc_speedup;
      dbg_pin_out <= bdc_speedup && !bdc_drive_low;
    end
  end

  // Bit time phase, restarted at each falling edge on the link
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_run || (dbg_s3_r && !dbg_s2_r)) begin
      bit_ph_r <= 4'h0;
      dbg_bit_tick <= 1'b0;
    end else begin
      bit_ph_r <= bit_ph_r + 4'h1;
      dbg_bit_tick <= bit_ph_r == `RPW_BIT_LAST;
    end
  end

  // Write channel capture, address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RPW_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= {aw_addr_r[11:2], 2'b00} > `RPW_ADDR_STAT ? `RPW_RESP_SLVERR : `RPW_RESP_OK;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // Option and port registers, restored on any reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_run) begin
      opt_en_r <= `RPW_EN_RST;
      opt_long_r <= `RPW_LONG_RST;
      opt_lock_r <= 1'b0;
      pg_en_r <= 1'b0;
      pg_val_r <= 1'b0;
    end else if (wr_go && w_strb_r[0]) begin
      if ({aw_addr_r[11:2], 2'b00} == `RPW_ADDR_OPTS && !opt_lock_r) begin
        opt_en_r <= w_data_r[`RPW_O_EN];
        opt_long_r <= w_data_r[`RPW_O_LONG];
        opt_lock_r <= 1'b1;
      end
      if ({aw_addr_r[11:2], 2'b00} == `RPW_ADDR_PORTG) begin
        pg_en_r <= w_data_r[`RPW_P_EN];
        pg_val_r <= w_data_r[`RPW_P_VAL];
      end
    end
  end

  // Service pulse on any write to the cause address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_service_r <= 1'b0;
    end else begin
      wd_service_r <= wr_go && {aw_addr_r[11:2], 2'b00} == `RPW_ADDR_CAUSE;
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case ({s_axi_araddr[11:2], 2'b00})
      `RPW_ADDR_CAUSE: rd_val[7:0] = cause_r;
      `RPW_ADDR_OPTS: begin
        rd_val[`RPW_O_EN] = opt_en_r;
        rd_val[`RPW_O_LONG] = opt_long_r;
        rd_val[`RPW_O_LOCK] = opt_lock_r;
      end
      `RPW_ADDR_PORTG: rd_val[`RPW_P_VAL:`RPW_P_EN] = {pg_val_r, pg_en_r};
      `RPW_ADDR_STAT: rd_val[3:0] = {state_r, dbg_s2_r, bg_mode};
      default: rd_err = 1'b1;
    endcase
  end

  // Read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RPW_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_err ? `RPW_RESP_SLVERR : `RPW_RESP_OK;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Watchdog hookup
  assign wd.enable = opt_en_r;
  assign wd.period_long = opt_long_r;
  assign wd.service = wd_service_r;
  assign wd.suspend = bg_mode;
  assign wd.clear = !in_run;

  rpw_wdog u_wdog (
    .aclk(aclk),
    .aresetn(aresetn),
    .wd(wd)
  );

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_drive_len: assert property ($rose(rst_pin_n_oe) |-> ##33 rst_pin_n_oe ##1 !rst_pin_n_oe)
    else $error("reset pin drive length wrong");
  a_pin_sample_gap: assert property ($fell(rst_pin_n_oe) |-> (state_r == RPW_SETTLE) [*8]
    ##30 state_r == RPW_SETTLE ##1 state_r != RPW_SETTLE)
    else $error("reset pin sample delay wrong");
  a_wd_starts_seq: assert property ((in_run && wd.timeout) |=>
    state_r == RPW_DRIVE && pend_r[`RPW_C_WDOG] && rst_pin_n_oe)
    else $error("watchdog timeout did not start reset");
  a_pin_cause_flag: assert property ((state_r == RPW_SETTLE && cnt_r == `RPW_SETTLE_LAST)
    |=> cause_r[`RPW_C_PIN] == !$past(rst_s2_r))
    else $error("pin cause flag mismatch");
  a_opts_locked: assert property ((opt_lock_r && in_run) ##1 in_run |-> $stable(opt_en_r))
    else $error("locked watchdog enable changed");
  a_mode_sample: assert property ($rose(sys_rst_n) |-> bg_mode == !$past(dbg_s2_r))
    else $error("mode select not sampled at release");
  a_port_out_only: assert property ((in_run && pg_en_r) |=> dbg_pin_oe)
    else $error("port bit not driven");
  a_dbg_quiet_rst: assert property (!in_run |=> !dbg_pin_oe && gpio_default)
    else $error("debug pin driven during reset");
  a_svc_keeps_cause: assert property ((wd_service_r && in_run) |=> $stable(cause_r))
    else $error("service write changed cause");
endmodule

//--- tb/rpw_far_end.sv
// Outside reset switch and debug pod on the two open-drain pins
`timescale 1ns/1ps
module rpw_far_end (
  input wire logic rst_oe, // Device drives reset pin
  input wire logic rst_out, // Device reset pin value
  input wire logic dbg_oe, // Device drives debug pin
  input wire logic dbg_out, // Device debug pin value
  input wire logic hold_rst, // Switch to ground closed
  input wire logic hold_dbg, // Pod holds debug pin low
  output logic rst_pin, // Resolved reset pin level
  output logic dbg_pin // Resolved debug pin level
);
  // Pullups win when nobody pulls low
  assign rst_pin = !(hold_rst || (rst_oe && !rst_out));
  assign dbg_pin = dbg_oe ? dbg_out : !hold_dbg;
endmodule

//--- tb/tb_top.sv
// Random and corner tests of reset sequencer and watchdog
`timescale 1ns/1ps
`include "rpw_defs.svh"
module tb_top;
  import rpw_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold_rst, hold_dbg;
  logic awready, wready, bvalid, arready, rvalid, rst_pin, rst_out, rst_oe, dbg_pin, dbg_out, dbg_oe;
  logic tick, sys_rst_n, self_mode, bg_mode, gpio_def, bdc_low, bdc_up;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [3:0] src;
  int n_fail, total_checks, cyc;
  rpw_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lvd_det(src[2]),
    .ilop_det(src[0]), .clk_loss_det(src[1]), .dbg_force_rst(src[3]), .rst_pin_n_in(rst_pin),
    .rst_pin_n_out(rst_out), .rst_pin_n_oe(rst_oe), .dbg_pin_in(dbg_pin), .dbg_pin_out(dbg_out),
    .dbg_pin_oe(dbg_oe), .bdc_drive_low(bdc_low), .bdc_speedup(bdc_up), .dbg_bit_tick(tick),
    .sys_rst_n(sys_rst_n), .clk_self_mode(self_mode), .bg_mode(bg_mode), .gpio_default(gpio_def));
  rpw_far_end far (.rst_oe(rst_oe), .rst_out(rst_out), .dbg_oe(dbg_oe), .dbg_out(dbg_out),
    .hold_rst(hold_rst), .hold_dbg(hold_dbg), .rst_pin(rst_pin), .dbg_pin(dbg_pin));
  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Pseudo-random source
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask
  // Times drive and settle phases, then reads the cause
  task automatic seq(logic [7:0] cause);
    int n;
    n = 0;
    while (!rst_oe) @(posedge aclk);
    while (rst_oe) begin
      if (n == 5) begin
        chk("sys_rst_n", 0, sys_rst_n);
        chk("self_mode", 1, self_mode);
        chk("gpio_def", 1, gpio_def);
        chk("dbg_oe", 0, dbg_oe);
      end
      n++;
      @(posedge aclk);
    end
    chk("drive_len", 34, n);
    n = 0;
    while (!sys_rst_n) begin
      n++;
      @(posedge aclk);
    end
    chk("settle_len", 38, n);
    rd(`RPW_ADDR_CAUSE, {24'h0, cause}, `RPW_RESP_OK);
    chk("self_run", 0, self_mode);
  endtask
  initial begin
    int n;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, hold_rst, hold_dbg, bdc_low, bdc_up} = 9'h000;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    src = 4'h0;
    cyc = 0;
    seed = 32'h73DD;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Power-on
    while (!sys_rst_n) @(posedge aclk);
    rd(`RPW_ADDR_CAUSE, 32'h80, `RPW_RESP_OK);
    rd(`RPW_ADDR_OPTS, 32'h3, `RPW_RESP_OK);
    rd(12'h010, 32'h0, `RPW_RESP_SLVERR);
    wr(12'h010, 32'h1, `RPW_RESP_SLVERR);
    // Each internal source, debug force sets no flag
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      src <= 4'h1 << i;
      @(posedge aclk);
      src <= 4'h0;
      seq(i == 0 ? 8'h10 : i == 1 ? 8'h04 : i == 2 ? 8'h02 : 8'h00);
    end
    // Debug bit time in normal mode
    while (!tick) @(posedge aclk);
    @(posedge aclk);
    n = 1;
    while (!tick) begin
      @(posedge aclk);
      n++;
    end
    chk("bit_time", 16, n);
    // Port bit drives only
    wr(`RPW_ADDR_PORTG, 32'h3, `RPW_RESP_OK);
    @(posedge aclk);
    chk("port_oe", 1, dbg_oe);
    chk("port_hi", 1, dbg_out);
    wr(`RPW_ADDR_PORTG, 32'h1, `RPW_RESP_OK);
    @(posedge aclk);
    chk("port_lo", 0, dbg_out);
    wr(`RPW_ADDR_PORTG, 32'h0, `RPW_RESP_OK);
    // Debug link low drive, speedup pulse, then released
    bdc_low <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("bdc_low", 2, {dbg_oe, dbg_out});
    {bdc_low, bdc_up} <= 2'b01;
    repeat (2) @(posedge aclk);
    chk("bdc_up", 3, {dbg_oe, dbg_out});
    bdc_up <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("bdc_off", 0, {dbg_oe, dbg_out});
    // Short period, lock, serviced at random times
    wr(`RPW_ADDR_OPTS, 32'h1, `RPW_RESP_OK);
    rd(`RPW_ADDR_OPTS, 32'h5, `RPW_RESP_OK);
    wr(`RPW_ADDR_OPTS, 32'h2, `RPW_RESP_OK);
    rd(`RPW_ADDR_OPTS, 32'h5, `RPW_RESP_OK);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(`RPW_ADDR_CAUSE, seed, `RPW_RESP_OK);
      rd(`RPW_ADDR_CAUSE, 32'h0, `RPW_RESP_OK);
      repeat (100 + seed[11:0]) @(posedge aclk);
      chk("serviced", 1, sys_rst_n);
    end
    wr(`RPW_ADDR_CAUSE, seed, `RPW_RESP_OK);
    n = 0;
    while (sys_rst_n) begin
      @(posedge aclk);
      n++;
    end
    chk("wd_span", 1, n > 8150 && n < 8250);
    seq(8'h20);
    rd(`RPW_ADDR_OPTS, 32'h3, `RPW_RESP_OK);
    // Background mode suspends the watchdog
    hold_dbg <= 1'b1;
    @(posedge aclk);
    src <= 4'h1;
    @(posedge aclk);
    src <= 4'h0;
    seq(8'h10);
    hold_dbg <= 1'b0;
    chk("bg_on", 1, bg_mode);
    repeat (2) @(posedge aclk);
    rd(`RPW_ADDR_STAT, 32'h3, `RPW_RESP_OK);
    wr(`RPW_ADDR_OPTS, 32'h1, `RPW_RESP_OK);
    repeat (8600) @(posedge aclk);
    chk("bg_hold", 1, sys_rst_n);
    rd(`RPW_ADDR_CAUSE, 32'h10, `RPW_RESP_OK);
    // Short switch press, released before the sample, sets no flag
    hold_rst <= 1'b1;
    while (!rst_oe) @(posedge aclk);
    hold_rst <= 1'b0;
    seq(8'h00);
    chk("bg_off", 0, bg_mode);
    // Switch held through the sample, reset kept until released
    hold_rst <= 1'b1;
    repeat (120) @(posedge aclk);
    chk("pin_hold", 0, sys_rst_n);
    hold_rst <= 1'b0;
    while (!sys_rst_n) @(posedge aclk);
    rd(`RPW_ADDR_CAUSE, 32'h40, `RPW_RESP_OK);
    // Cleared enable stops the watchdog
    wr(`RPW_ADDR_OPTS, 32'h0, `RPW_RESP_OK);
    rd(`RPW_ADDR_OPTS, 32'h4, `RPW_RESP_OK);
    repeat (8600) @(posedge aclk);
    chk("wd_off", 1, sys_rst_n);
    rd(`RPW_ADDR_CAUSE, 32'h40, `RPW_RESP_OK);
    summarize();
  end
endmodule
